//--- common/dmh_defines.svh
// constants for the diagnostic message history store
`ifndef DMH_DEFINES_SVH
`define DMH_DEFINES_SVH

`define DMH_DEPTH         250
`define DMH_SUBIDX_BASE   8'h06
`define DMH_CLK_PERIOD_NS 8'h0A

// register word offsets, compared with PADDR_IN[7:2]
`define DMH_OFS_NEWEST    6'h00
`define DMH_OFS_CTRL      6'h01
`define DMH_OFS_STATUS    6'h02
`define DMH_OFS_SEL       6'h03
`define DMH_OFS_CODE      6'h04
`define DMH_OFS_FLAGTEXT  6'h05
`define DMH_OFS_TS_LO     6'h06
`define DMH_OFS_TS_HI     6'h07
`define DMH_OFS_PARAM0    6'h08
`define DMH_OFS_PARAM1    6'h09
`define DMH_OFS_PARAM2    6'h0A
`define DMH_OFS_INFO      6'h0B
`define DMH_OFS_IRQ_STAT  6'h0C
`define DMH_OFS_IRQ_CLR   6'h0D
`define DMH_OFS_IRQ_EN    6'h0E

// control fields and reset values
`define DMH_CTRL_EMCY_BIT 0
`define DMH_CTRL_ACK_BIT  1
`define DMH_EMCY_EN_RST   1'b1
`define DMH_IRQ_EN_RST    3'h0

// interrupt status bits
`define DMH_IRQ_NEW       0
`define DMH_IRQ_OVWR      1
`define DMH_IRQ_ACK       2

// text identifier nibbles, init text identifier and info flags
`define DMH_CLASS_SYSINFO 4'h0
`define DMH_CLASS_INFO    4'h1
`define DMH_PLACE_SYSTEM  4'h0
`define DMH_TEXT_INIT     16'h0003
`define DMH_FLAGS_INFO    16'h0000

`endif

//--- common/dmh_pkg.sv
// types of the diagnostic message history store
`include "dmh_defines.svh"
package dmh_pkg;
    typedef enum logic [0:0] {ACK_IDLE, ACK_SCAN} dmh_ack_st_t;

    typedef struct packed {
        logic [31:0]      code;
        logic [15:0]      flags;
        logic [15:0]      text_id;
        logic [63:0]      tstamp;
        logic [2:0][31:0] params;
        logic [1:0]       param_cnt;
    } dmh_rec_t;

    typedef struct packed {
        logic [7:0]            wr_slot;
        logic [7:0]            count;
        logic                  pend_new;
        logic                  emcy_en;
        logic [3:0]            last_dev_state;
        logic                  state_pend;
        logic [15:0]           state_text;
        logic                  init_pend;
        logic [2:0]            irq_stat;
        logic [2:0]            irq_en;
        logic [7:0]            sel;
        logic [`DMH_DEPTH-1:0] acked;
        dmh_ack_st_t           ack_st;
        logic [7:0]            scan_slot;
        logic [7:0]            scan_left;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
        logic                  evt_ready;
        logic                  emcy_req;
        logic [7:0]            emcy_subidx;
        logic                  irq;
    } dmh_state_t;
endpackage

//--- hw/dmh_reset_sync.sv
// two-stage release of the asynchronous reset
module dmh_reset_sync (
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    output wire logic rst_n_out
);
    logic [1:0] sync_ff;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_ff <= 2'h0;
        end else begin
            sync_ff <= {sync_ff[0], 1'b1};
        end
    end

    assign rst_n_out = sync_ff[1];
endmodule

//--- hw/dmh_timestamp.sv
// timestamp source: distributed clock time or local nanosecond counter
`include "dmh_defines.svh"
module dmh_timestamp (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        dc_present_in,
    input  wire logic [63:0] dc_time_in,
    output wire logic [63:0] tstamp_out
);
    logic [63:0] local_ns_ff;

    // local time only stands in for the clock; it starts at zero after reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            local_ns_ff <= 64'h0000_0000_0000_0000;
        end else begin
            local_ns_ff <= local_ns_ff + {56'h0, `DMH_CLK_PERIOD_NS};
        end
    end

    assign tstamp_out = dc_present_in ? dc_time_in : local_ns_ff;
endmodule

//--- hw/dmh_diag_history.sv
// diagnostic message history store with apb register access
`include "dmh_defines.svh"
module dmh_diag_history (
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        ARST_N_IN,
    // apb slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // event source
    input  wire logic        EVT_VALID_IN,
    input  wire logic [31:0] EVT_CODE_IN,
    input  wire logic [15:0] EVT_FLAGS_IN,
    input  wire logic [15:0] EVT_TEXT_ID_IN,
    input  wire logic [95:0] EVT_PARAMS_IN,
    input  wire logic [1:0]  EVT_PARAM_CNT_IN,
    output logic             EVT_READY_OUT,
    // time and device state
    input  wire logic        DC_PRESENT_IN,
    input  wire logic [63:0] DC_TIME_IN,
    input  wire logic [3:0]  DEV_STATE_IN,
    // emergency and interrupt
    output logic             EMCY_REQ_OUT,
    output logic      [7:0]  EMCY_SUBIDX_OUT,
    output logic             IRQ_OUT
);
    logic                 rst_n;
    logic [63:0]          tstamp;
    dmh_pkg::dmh_state_t  st_ff;
    dmh_pkg::dmh_state_t  nxt_st;
    dmh_pkg::dmh_rec_t    mem [0:`DMH_DEPTH-1];
    dmh_pkg::dmh_rec_t    rec_new;
    dmh_pkg::dmh_rec_t    rec_view;
    logic                 rec_we;
    logic                 apb_wr;
    logic                 apb_rd;
    logic [7:0]           newest_slot;
    logic [7:0]           newest_subidx;
    logic [31:0]          rd_data;
    logic                 addr_ok;

    dmh_reset_sync u_rst (
        .clk_in    (CLK_IN),
        .arst_n_in (ARST_N_IN),
        .rst_n_out (rst_n)
    );

    dmh_timestamp u_ts (
        .clk_in        (CLK_IN),
        .rst_n_in      (rst_n),
        .dc_present_in (DC_PRESENT_IN),
        .dc_time_in    (DC_TIME_IN),
        .tstamp_out    (tstamp)
    );

    assign newest_slot   = (st_ff.wr_slot == 8'h00) ? 8'(`DMH_DEPTH - 1) : st_ff.wr_slot - 8'h01;
    assign newest_subidx = (st_ff.count == 8'h00) ? 8'h00 : newest_slot + `DMH_SUBIDX_BASE;
    assign rec_view      = (st_ff.sel < 8'(`DMH_DEPTH)) ? mem[st_ff.sel] : '0;
    assign apb_wr        = PSEL_IN & PENABLE_IN & st_ff.pready & PWRITE_IN;
    assign apb_rd        = PSEL_IN & PENABLE_IN & st_ff.pready & ~PWRITE_IN;

    // read mux; record words read as zero only when sel is at or above the depth
    always_comb begin
        rd_data = 32'h0000_0000;
        addr_ok = 1'b1;
        unique case (PADDR_IN[7:2])
            `DMH_OFS_NEWEST:   rd_data = {24'h0, newest_subidx};
            `DMH_OFS_CTRL:     rd_data = {31'h0, st_ff.emcy_en};
            `DMH_OFS_STATUS:   rd_data = {16'h0, st_ff.count, 7'h0, st_ff.pend_new};
            `DMH_OFS_SEL:      rd_data = {24'h0, st_ff.sel};
            `DMH_OFS_CODE:     rd_data = rec_view.code;
            `DMH_OFS_FLAGTEXT: rd_data = {rec_view.text_id, rec_view.flags};
            `DMH_OFS_TS_LO:    rd_data = rec_view.tstamp[31:0];
            `DMH_OFS_TS_HI:    rd_data = rec_view.tstamp[63:32];
            `DMH_OFS_PARAM0:   rd_data = rec_view.params[0];
            `DMH_OFS_PARAM1:   rd_data = rec_view.params[1];
            `DMH_OFS_PARAM2:   rd_data = rec_view.params[2];
            `DMH_OFS_INFO:     rd_data = {29'h0, rec_view.param_cnt,
                                          (st_ff.sel < 8'(`DMH_DEPTH)) ? st_ff.acked[st_ff.sel] : 1'b0};
            `DMH_OFS_IRQ_STAT: rd_data = {29'h0, st_ff.irq_stat};
            `DMH_OFS_IRQ_CLR:  rd_data = 32'h0000_0000;
            `DMH_OFS_IRQ_EN:   rd_data = {29'h0, st_ff.irq_en};
            default:           addr_ok = 1'b0;
        endcase
    end

    always_comb begin
        nxt_st   = st_ff;
        rec_we   = 1'b0;
        rec_new  = '0;

        // apb: one wait state, then pready from a flop
        nxt_st.pready = PSEL_IN & PENABLE_IN & ~st_ff.pready;
        if (nxt_st.pready) begin
            nxt_st.prdata  = PWRITE_IN ? 32'h0000_0000 : rd_data;
            nxt_st.pslverr = ~addr_ok;
        end

        // software clears go first so hardware sets below win
        if (apb_wr) begin
            unique case (PADDR_IN[7:2])
                `DMH_OFS_CTRL: begin
                    nxt_st.emcy_en = PWDATA_IN[`DMH_CTRL_EMCY_BIT];
                    if (PWDATA_IN[`DMH_CTRL_ACK_BIT] && st_ff.ack_st == dmh_pkg::ACK_IDLE &&
                        st_ff.count != 8'h00) begin
                        nxt_st.ack_st    = dmh_pkg::ACK_SCAN;
                        nxt_st.scan_slot = newest_slot;
                        nxt_st.scan_left = st_ff.count;
                    end
                end
                `DMH_OFS_SEL:     nxt_st.sel      = PWDATA_IN[7:0];
                `DMH_OFS_IRQ_CLR: nxt_st.irq_stat = st_ff.irq_stat & ~PWDATA_IN[2:0];
                `DMH_OFS_IRQ_EN:  nxt_st.irq_en   = PWDATA_IN[2:0];
                default: begin
                end
            endcase
        end

        // reading any word of the newest record counts as having read it
        if (apb_rd && PADDR_IN[7:2] >= `DMH_OFS_CODE && PADDR_IN[7:2] <= `DMH_OFS_INFO &&
            st_ff.sel == newest_slot && st_ff.count != 8'h00) begin
            nxt_st.pend_new = 1'b0;
        end

        // acknowledge walks back from the newest record to the first unconfirmed one
        unique case (st_ff.ack_st)
            dmh_pkg::ACK_IDLE: begin
            end
            dmh_pkg::ACK_SCAN: begin
                if (!st_ff.acked[st_ff.scan_slot]) begin
                    nxt_st.acked[st_ff.scan_slot]  = 1'b1;
                    nxt_st.irq_stat[`DMH_IRQ_ACK] = 1'b1;
                    nxt_st.ack_st                 = dmh_pkg::ACK_IDLE;
                end else if (st_ff.scan_left <= 8'h01) begin
                    nxt_st.ack_st = dmh_pkg::ACK_IDLE;
                end else begin
                    nxt_st.scan_left = st_ff.scan_left - 8'h01;
                    nxt_st.scan_slot = (st_ff.scan_slot == 8'h00) ? 8'(`DMH_DEPTH - 1) : st_ff.scan_slot - 8'h01;
                end
            end
        endcase

        // record source: init record, then state change, then external event
        if (st_ff.init_pend) begin
            rec_we            = 1'b1;
            rec_new.flags     = `DMH_FLAGS_INFO;
            rec_new.text_id   = `DMH_TEXT_INIT;
            rec_new.params[0] = {31'h0, DC_PRESENT_IN};
            rec_new.params[1] = 32'(`DMH_DEPTH);
            rec_new.params[2] = {28'h0, DEV_STATE_IN};
            rec_new.param_cnt = 2'h3;
            nxt_st.init_pend  = 1'b0;
        end else if (st_ff.state_pend) begin
            rec_we            = 1'b1;
            rec_new.flags     = `DMH_FLAGS_INFO;
            rec_new.text_id   = st_ff.state_text;
            nxt_st.state_pend = 1'b0;
        end else if (EVT_VALID_IN && st_ff.evt_ready) begin
            rec_we            = 1'b1;
            rec_new.code      = EVT_CODE_IN;
            rec_new.flags     = EVT_FLAGS_IN;
            rec_new.text_id   = EVT_TEXT_ID_IN;
            rec_new.params    = EVT_PARAMS_IN;
            rec_new.param_cnt = EVT_PARAM_CNT_IN;
        end
        rec_new.tstamp = tstamp;

        nxt_st.emcy_req = 1'b0;
        if (rec_we) begin
            nxt_st.acked[st_ff.wr_slot]   = 1'b0;
            nxt_st.wr_slot                = (st_ff.wr_slot == 8'(`DMH_DEPTH - 1)) ? 8'h00 : st_ff.wr_slot + 8'h01;
            nxt_st.count                  = (st_ff.count == 8'(`DMH_DEPTH)) ? st_ff.count : st_ff.count + 8'h01;
            nxt_st.pend_new               = 1'b1;
            nxt_st.irq_stat[`DMH_IRQ_NEW] = 1'b1;
            if (st_ff.count == 8'(`DMH_DEPTH)) begin
                nxt_st.irq_stat[`DMH_IRQ_OVWR] = 1'b1;
            end
            nxt_st.emcy_req    = st_ff.emcy_en;
            nxt_st.emcy_subidx = st_ff.wr_slot + `DMH_SUBIDX_BASE;
        end

        // only a change between two valid states is logged; a second change in the
        // cycle the pending one is written becomes the next pending one, so neither is lost
        if (DEV_STATE_IN != st_ff.last_dev_state) begin
            nxt_st.last_dev_state = DEV_STATE_IN;
            if (st_ff.last_dev_state != 4'h0 && DEV_STATE_IN != 4'h0) begin
                nxt_st.state_pend = 1'b1;
                nxt_st.state_text = {`DMH_CLASS_INFO, `DMH_PLACE_SYSTEM, st_ff.last_dev_state, DEV_STATE_IN};
            end
        end

        nxt_st.evt_ready = ~nxt_st.init_pend & ~nxt_st.state_pend;
        nxt_st.irq       = |(nxt_st.irq_stat & nxt_st.irq_en);
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            st_ff           <= '0;
            st_ff.emcy_en   <= `DMH_EMCY_EN_RST;
            st_ff.irq_en    <= `DMH_IRQ_EN_RST;
            st_ff.init_pend <= 1'b1;
            st_ff.acked     <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // record storage has no reset; unwritten slots below the depth read back their unknown contents
    always_ff @(posedge CLK_IN) begin
        if (rec_we) begin
            mem[st_ff.wr_slot] <= rec_new;
        end
    end

    assign PRDATA_OUT      = st_ff.prdata;
    assign PREADY_OUT      = st_ff.pready;
    assign PSLVERR_OUT     = st_ff.pslverr;
    assign EVT_READY_OUT   = st_ff.evt_ready;
    assign EMCY_REQ_OUT    = st_ff.emcy_req;
    assign EMCY_SUBIDX_OUT = st_ff.emcy_subidx;
    assign IRQ_OUT         = st_ff.irq;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!rst_n);

    sequence s_ctrl_write;
        PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT && PADDR_IN[7:2] == `DMH_OFS_CTRL;
    endsequence

    sequence s_state_change;
        DEV_STATE_IN != st_ff.last_dev_state && st_ff.last_dev_state != 4'h0 && DEV_STATE_IN != 4'h0;
    endsequence

    AST_NEWEST_FOLLOWS: assert property (rec_we |=> newest_subidx == $past(st_ff.wr_slot) + `DMH_SUBIDX_BASE)
        else $error("newest subindex does not follow the written slot");
    AST_COUNT_GROWS: assert property (rec_we && st_ff.count < 8'(`DMH_DEPTH) |=> st_ff.count == $past(st_ff.count) + 8'h01)
        else $error("record count did not grow");
    AST_FULL_OVERWRITE: assert property (rec_we && st_ff.count == 8'(`DMH_DEPTH)
                                         |=> st_ff.count == 8'(`DMH_DEPTH) && st_ff.irq_stat[`DMH_IRQ_OVWR])
        else $error("full history not overwritten correctly");
    AST_PENDING_SET: assert property (rec_we |=> st_ff.pend_new)
        else $error("new record not flagged as pending");
    AST_ACK_ENDS: assert property ($rose(st_ff.ack_st == dmh_pkg::ACK_SCAN) |-> ##[1:251] st_ff.ack_st == dmh_pkg::ACK_IDLE)
        else $error("acknowledge scan did not finish");
    AST_ACK_MARKS: assert property (st_ff.ack_st == dmh_pkg::ACK_SCAN && !st_ff.acked[st_ff.scan_slot]
                                    |=> st_ff.acked[$past(st_ff.scan_slot)] && st_ff.irq_stat[`DMH_IRQ_ACK])
        else $error("acknowledged record not marked");
    AST_NEW_UNACKED: assert property (rec_we |=> !st_ff.acked[$past(st_ff.wr_slot)])
        else $error("new record not unconfirmed");
    AST_EMCY_PULSE: assert property (rec_we && st_ff.emcy_en |=> EMCY_REQ_OUT ##1 (!EMCY_REQ_OUT || $past(rec_we)))
        else $error("emergency not announced");
    AST_EMCY_CTRL: assert property (s_ctrl_write |=> st_ff.emcy_en == $past(PWDATA_IN[`DMH_CTRL_EMCY_BIT]))
        else $error("emergency enable not taken from write");
    AST_STATE_LOGGED: assert property (s_state_change |-> ##[1:2] (rec_we && rec_new.text_id[15:8] == 8'h10))
        else $error("state change not logged");
    AST_TSTAMP: assert property (rec_we |=> mem[$past(st_ff.wr_slot)].tstamp == $past(tstamp))
        else $error("timestamp not stored");
endmodule

//--- testbench/dmh_evt_source.sv
// event source model offering records to the history store
module dmh_evt_source (
    // clock and handshake
    input  wire logic        clk_in,
    input  wire logic        ready_in,
    // record offer
    output logic             valid_out,
    output logic      [31:0] code_out,
    output logic      [15:0] flags_out,
    output logic      [15:0] text_out,
    output logic      [95:0] params_out,
    output logic      [1:0]  cnt_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        valid_out = 1'b0;
        code_out = 32'h0000_0000;
        flags_out = 16'h0000;
        text_out = 16'h0000;
        params_out = '0;
        cnt_out = 2'h0;
    end
    // offer held until taken; afterwards fields are scrambled so stale data never looks valid
    task automatic send(input logic [31:0] c, input logic [15:0] f, input logic [15:0] t);
        @(posedge clk_in);
        valid_out <= 1'b1;
        code_out <= c;
        flags_out <= f;
        text_out <= t;
        params_out <= {c + 32'h0000_0002, c + 32'h0000_0001, c};
        cnt_out <= 2'h3;
        for (int i = 0; i < 1000; i++) begin
            @(posedge clk_in);
            if (ready_in === 1'b1) break;
        end
        valid_out <= 1'b0;
        code_out <= ~c;
        flags_out <= ~f;
        text_out <= ~t;
        params_out <= ~{c + 32'h0000_0002, c + 32'h0000_0001, c};
        cnt_out <= 2'h0;
    endtask
endmodule

//--- testbench/dmh_diag_history_bench.sv
// self-checking bench of the diagnostic message history store
module dmh_diag_history_bench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} dmh_row_t;
    logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        dc_present = 1'b0, err_seen;
    logic [7:0]  paddr = 8'h00, emcy_sub;
    logic [31:0] pwdata = 32'h0000_0000, rdata, prdata;
    logic [63:0] dc_time = 64'h0123_4567_89AB_CDEF;
    logic [3:0]  dev_state = 4'h1, st;
    logic        pready, pslverr, evt_valid, evt_ready, emcy_req, irq;
    logic [31:0] evt_code;
    logic [15:0] evt_flags, evt_text;
    logic [95:0] evt_params;
    logic [1:0]  evt_cnt;
    logic [7:0]  emcy_subidx;
    int          err_count = 0, tests_run = 0, n_rec = 1, emcy_n = 0;
    logic [3:0]  states [7] = '{4'h2, 4'h4, 4'h2, 4'h1, 4'h2, 4'h4, 4'h8};
    logic [15:0] ids [7] = '{16'h1012, 16'h1024, 16'h1042, 16'h1021, 16'h1012, 16'h1024, 16'h1048};
    dmh_row_t    rows [12] = '{'{0, 8'h00, 0, 32'h0000_0006, 0}, '{0, 8'h08, 0, 32'h0000_0101, 0},
        '{0, 8'h14, 0, 32'h0003_0000, 0}, '{0, 8'h20, 0, 32'h0000_0000, 0}, '{0, 8'h24, 0, 32'h0000_00FA, 0},
        '{0, 8'h28, 0, 32'h0000_0001, 0}, '{0, 8'h2C, 0, 32'h0000_0006, 0}, '{0, 8'h38, 0, 32'h0000_0000, 0},
        '{0, 8'h04, 0, 32'h0000_0001, 0}, '{0, 8'h3C, 0, 32'h0000_0000, 1}, '{1, 8'h00, 32'h0000_0055, 0, 0},
        '{0, 8'h08, 0, 32'h0000_0100, 0}};

    dmh_diag_history i_dmh_diag_history (.CLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .EVT_VALID_IN(evt_valid), .EVT_CODE_IN(evt_code), .EVT_FLAGS_IN(evt_flags),
        .EVT_TEXT_ID_IN(evt_text), .EVT_PARAMS_IN(evt_params), .EVT_PARAM_CNT_IN(evt_cnt),
        .EVT_READY_OUT(evt_ready), .DC_PRESENT_IN(dc_present), .DC_TIME_IN(dc_time), .DEV_STATE_IN(dev_state),
        .EMCY_REQ_OUT(emcy_req), .EMCY_SUBIDX_OUT(emcy_subidx), .IRQ_OUT(irq));
    dmh_evt_source i_dmh_evt_source (.clk_in(clk), .ready_in(evt_ready), .valid_out(evt_valid),
        .code_out(evt_code), .flags_out(evt_flags), .text_out(evt_text), .params_out(evt_params),
        .cnt_out(evt_cnt));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (emcy_req === 1'b1) begin
            emcy_n <= emcy_n + 1;
            emcy_sub <= emcy_subidx;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // request held until pready is sampled high; no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rdata = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdata, x);
    endtask
    task automatic srd(input logic [7:0] s, input logic [7:0] a, input logic [31:0] x);
        apb(1'b1, 8'h0C, {24'h00_0000, s});
        rd(a, x);
    endtask
    task automatic print_verdict;
        if (err_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #500000;
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk({31'h0, err_seen}, {31'h0, rows[i].e});
            if (!rows[i].w && !rows[i].e) chk(rdata, rows[i].x);
        end
        // stored event: content, timestamp, emergency and interrupt
        apb(1'b1, 8'h38, 32'h0000_0001);
        dc_present <= 1'b1;
        i_dmh_evt_source.send(32'h1234_5678, 16'h0002, 16'h4413);
        n_rec++;
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0001);
        chk(emcy_n, 2);
        chk({24'h0, emcy_sub}, 32'h0000_0007);
        srd(8'h01, 8'h10, 32'h1234_5678);
        rd(8'h14, 32'h4413_0002);
        rd(8'h18, 32'h89AB_CDEF);
        rd(8'h1C, 32'h0123_4567);
        rd(8'h20, 32'h1234_5678);
        rd(8'h28, 32'h1234_567A);
        rd(8'h2C, 32'h0000_0006);
        rd(8'h08, 32'h0000_0200);
        apb(1'b1, 8'h34, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        // emergency off, then on again
        apb(1'b1, 8'h04, 32'h0000_0000);
        i_dmh_evt_source.send(32'h0000_00A1, 16'h0001, 16'h1100);
        repeat (3) @(posedge clk);
        chk(emcy_n, 2);
        rd(8'h04, 32'h0000_0000);
        apb(1'b1, 8'h04, 32'h0000_0001);
        i_dmh_evt_source.send(32'h0000_00A2, 16'h0001, 16'h1100);
        n_rec += 2;
        repeat (3) @(posedge clk);
        chk(emcy_n, 3);
        chk({24'h0, emcy_sub}, 32'h0000_0009);
        // device state transitions, forward and backward
        foreach (states[i]) begin
            st = states[i];
            @(posedge clk);
            dev_state <= st;
            repeat (4) @(posedge clk);
            n_rec++;
            srd(n_rec - 1, 8'h14, {ids[i], 16'h0000});
            rd(8'h00, n_rec + 5);
        end
        // two acknowledges confirm the two newest records, the third stays open
        for (int k = 1; k <= 2; k++) begin
            apb(1'b1, 8'h04, 32'h0000_0003);
            for (int i = 0; i < 100; i++) begin
                apb(1'b0, 8'h30, 32'h0000_0000);
                if (rdata[2] === 1'b1) break;
            end
            chk(rdata & 32'h0000_0004, 32'h0000_0004);
            apb(1'b1, 8'h34, 32'h0000_0004);
            srd(n_rec - k, 8'h2C, 32'h0000_0001);
        end
        srd(n_rec - 3, 8'h2C, 32'h0000_0000);
        // fill past the depth so the oldest slot is replaced
        for (int k = n_rec; k < 251; k++) i_dmh_evt_source.send(32'h0000_B000 + k, 16'h0000, 16'h1000);
        repeat (3) @(posedge clk);
        rd(8'h30, 32'h0000_0003);
        rd(8'h08, 32'h0000_FA01);
        rd(8'h00, 32'h0000_0006);
        srd(8'h00, 8'h10, 32'h0000_B0FA);
        // reset in mid-run: history empties, only the init record is stored again
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(8'h08, 32'h0000_0101);
        rd(8'h00, 32'h0000_0006);
        rd(8'h14, 32'h0003_0000);
        print_verdict();
    end
endmodule
